/* File: cpu_flags_pkg.sv */
// Constants and types for the flag, call-save and address generation slice
package cpu_flags_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 14;
    localparam int TARGET_W = 20;

    // ----------------------------------------
    // Flag register layout
    // ----------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam int FLAG_PD = 5;
    localparam int FLAG_TO = 6;
    localparam int FLAG_UNUSED = 7;
    localparam logic [7:0] FLAGS_RESET = 8'h60;

    // ----------------------------------------
    // Register port indexes
    // ----------------------------------------
    localparam logic [3:0] REG_FLAGS = 4'h0;
    localparam logic [3:0] REG_WORKING = 4'h1;
    localparam logic [3:0] REG_BANK = 4'h2;
    localparam logic [3:0] REG_SAVED_FLAGS = 4'h3;
    localparam logic [3:0] REG_SAVED_WORKING = 4'h4;
    localparam logic [3:0] REG_SAVED_BANK = 4'h5;
    localparam logic [3:0] REG_PTR_BASE = 4'h6;
    localparam int PTR_COUNT = 3;

    // ----------------------------------------
    // Data address map
    // ----------------------------------------
    localparam logic [13:0] FLAGS_DATA_ADDR = 14'h3FD8;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [5:0] ACCESS_LOW_PAGE = 6'h00;
    localparam logic [5:0] ACCESS_HIGH_PAGE = 6'h3F;
    localparam logic [7:0] INDEXED_MAX = 8'h5F;

    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_RLC, OP_RRC,
        OP_CLR, OP_BCLR, OP_BSET, OP_SWAP, OP_MOVE
    } alu_op_t;

    typedef enum logic [1:0] {
        AM_DIRECT, AM_LONG, AM_INDIRECT
    } addr_mode_t;

    typedef enum logic [2:0] {
        IND_PLAIN, IND_AFTER_ACCESS_INCREMENT_OPERAND, IND_AFTER_ACCESS_DECREMENT_OPERAND, IND_BEFORE_ACCESS_INCREMENT_OPERAND, IND_WORKING_OFFSET_OPERAND
    } ind_mode_t;

endpackage

/* File: cpu_flags_addr.sv */
// ALU flags, call-save registers and data address generation
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cpu_flags_addr
    import cpu_flags_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic extendedIsaEnable,
    input wire logic execStart,
    input wire alu_op_t aluOp,
    input wire logic [7:0] fileOperand,
    input wire logic useLiteral,
    input wire logic [7:0] literal,
    input wire logic [2:0] bitIndex,
    input wire logic destToFile,
    input wire logic [13:0] targetAddr,
    output logic resultValid,
    output logic [7:0] resultData,
    output logic resultToWorking,
    output logic resultWriteFile,
    input wire logic callEvent,
    input wire logic watchdogClearInstr,
    input wire logic sleepInstr,
    input wire logic watchdogTimeout,
    input wire logic addrReq,
    input wire addr_mode_t addrMode,
    input wire logic [7:0] opcodeLowByte,
    input wire logic accessSelect,
    input wire logic [13:0] longAddr,
    input wire logic [1:0] pointerSel,
    input wire ind_mode_t indirectMode,
    output logic addrValid,
    output logic [13:0] dataAddr,
    input wire logic branchReq,
    input wire logic [15:0] opcodeFirst,
    input wire logic [15:0] opcodeSecond,
    output logic branchValid,
    output logic [19:0] branchTarget
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rstMeta_reg;
    logic rstSyncN;

    default clocking checkClock @(posedge clock);
    endclocking
    default disable iff (!rstSyncN);

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rstMeta_reg <= 1'b0;
            rstSyncN <= 1'b0;
        end
        else
        begin
            rstMeta_reg <= 1'b1;
            rstSyncN <= rstMeta_reg;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Returns {overflow, nibble carry, carry, sum}
    function automatic logic [10:0] addCore(input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic cin);
        logic [8:0] s;
        logic [4:0] lo;
        logic ov;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        ov = (a[7] == b[7]) && (s[7] != a[7]);
        return {ov, lo[4], s[8], s[7:0]};
    endfunction

    // Whole-pair step: low byte wrap carries into the high part
    function automatic logic [13:0] ptrStep(input logic [13:0] p,
                                            input logic up);
        return up ? p + 14'h0001 : p - 14'h0001;
    endfunction

    logic [7:0] flags_reg;
    logic [7:0] working_reg;
    logic [7:0] bank_reg;
    logic [7:0] savedFlags_reg;
    logic [7:0] savedWorking_reg;
    logic [7:0] savedBank_reg;
    logic [13:0] ptr_reg [PTR_COUNT];

    // ----------------------------------------
    // ALU and flag calculation
    // ----------------------------------------
    logic [7:0] opB;
    logic [10:0] addOut;
    logic [10:0] subOut;
    logic [7:0] aluRes;
    logic [4:0] calcFlags;
    logic [4:0] flagMask;
    logic [4:0] flags_next;
    logic targetIsFlags;
    logic flagOp;

    always_comb
    begin
        opB = useLiteral ? literal : working_reg;
        addOut = addCore(fileOperand, opB, 1'b0);
        subOut = addCore(fileOperand, ~opB, 1'b1);
        aluRes = fileOperand;
        calcFlags = flags_reg[4:0];
        flagMask = 5'h00;
        case (aluOp)
            OP_ADD, OP_SUB:
            begin
                aluRes = (aluOp == OP_ADD) ? addOut[7:0] : subOut[7:0];
                calcFlags[FLAG_C] = (aluOp == OP_ADD) ? addOut[8]
                                                      : subOut[8];
                calcFlags[FLAG_DC] = (aluOp == OP_ADD) ? addOut[9]
                                                       : subOut[9];
                calcFlags[FLAG_OV] = (aluOp == OP_ADD) ? addOut[10]
                                                       : subOut[10];
                flagMask = 5'h1F;
            end
            OP_AND, OP_IOR, OP_XOR:
            begin
                if (aluOp == OP_AND)
                    aluRes = fileOperand & opB;
                else if (aluOp == OP_IOR)
                    aluRes = fileOperand | opB;
                else
                    aluRes = fileOperand ^ opB;
                flagMask = 5'h14;
            end
            OP_RLC:
            begin
                aluRes = {fileOperand[6:0], flags_reg[FLAG_C]};
                calcFlags[FLAG_C] = fileOperand[7];
                flagMask = 5'h15;
            end
            OP_RRC:
            begin
                aluRes = {flags_reg[FLAG_C], fileOperand[7:1]};
                calcFlags[FLAG_C] = fileOperand[0];
                flagMask = 5'h15;
            end
            OP_CLR:
            begin
                aluRes = 8'h00;
                flagMask = 5'h04;
            end
            // Flag-neutral group: the safe way to edit flags
            OP_BCLR: aluRes = fileOperand & ~(8'h01 << bitIndex);
            OP_BSET: aluRes = fileOperand | (8'h01 << bitIndex);
            OP_SWAP: aluRes = {fileOperand[3:0], fileOperand[7:4]};
            OP_MOVE: aluRes = fileOperand;
            default: aluRes = fileOperand;
        endcase
        calcFlags[FLAG_Z] = (aluRes == 8'h00);
        calcFlags[FLAG_N] = aluRes[7];
        flags_next = (flags_reg[4:0] & ~flagMask) | (calcFlags & flagMask);
        flagOp = |flagMask;
        targetIsFlags = destToFile && (targetAddr == FLAGS_DATA_ADDR);
    end

    // ----------------------------------------
    // Flag register
    // ----------------------------------------
    // Hardware events come last so they win over software writes
    always_ff @(posedge clock or negedge rstSyncN)
    begin
        if (!rstSyncN)
            flags_reg <= FLAGS_RESET;
        else
        begin
            if (regWrite && regAddr == REG_FLAGS)
                flags_reg[4:0] <= regWrData[4:0];
            if (execStart && flagOp)
                flags_reg[4:0] <= flags_next;
            else if (execStart && targetIsFlags)
                flags_reg[4:0] <= aluRes[4:0];
            if (watchdogClearInstr)
            begin
                flags_reg[FLAG_TO] <= 1'b1;
                flags_reg[FLAG_PD] <= 1'b1;
            end
            else if (sleepInstr)
            begin
                flags_reg[FLAG_TO] <= 1'b1;
                flags_reg[FLAG_PD] <= 1'b0;
            end
            if (watchdogTimeout)
                flags_reg[FLAG_TO] <= 1'b0;
            flags_reg[FLAG_UNUSED] <= 1'b0;
        end
    end

    // ----------------------------------------
    // Working and bank select registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstSyncN)
    begin
        if (!rstSyncN)
            working_reg <= 8'h00;
        else if (execStart && !destToFile)
            working_reg <= aluRes;
        else if (regWrite && regAddr == REG_WORKING)
            working_reg <= regWrData;
    end

    always_ff @(posedge clock or negedge rstSyncN)
    begin
        if (!rstSyncN)
            bank_reg <= 8'h00;
        else if (regWrite && regAddr == REG_BANK)
            bank_reg <= {2'b00, regWrData[5:0]};
    end

    // ----------------------------------------
    // Call save registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            savedFlags_reg <= 8'h00;
            savedWorking_reg <= 8'h00;
            savedBank_reg <= 8'h00;
        end
        else if (callEvent)
        begin
            savedFlags_reg <= flags_reg;
            savedWorking_reg <= working_reg;
            savedBank_reg <= bank_reg;
        end
    end

    // ----------------------------------------
    // ALU result outputs
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            resultValid <= 1'b0;
            resultData <= 8'h00;
            resultToWorking <= 1'b0;
            resultWriteFile <= 1'b0;
        end
        else
        begin
            resultValid <= execStart;
            if (execStart)
                resultData <= aluRes;
            resultToWorking <= execStart && !destToFile;
            // Flag register target is absorbed here, never written out
            resultWriteFile <= execStart && destToFile
                               && !targetIsFlags;
        end
    end

    // ----------------------------------------
    // Data address generation
    // ----------------------------------------
    logic [13:0] selPtr;
    logic [13:0] addr_next;
    logic adjustPtr;
    logic adjustUp;

    always_comb
    begin
        selPtr = ptr_reg[0];
        if (pointerSel == 2'd1)
            selPtr = ptr_reg[1];
        else if (pointerSel == 2'd2)
            selPtr = ptr_reg[2];
        addr_next = longAddr;
        adjustPtr = 1'b0;
        adjustUp = 1'b1;
        if (addrMode == AM_DIRECT)
        begin
            if (accessSelect)
                addr_next = {bank_reg[5:0], opcodeLowByte};
            else if (extendedIsaEnable && opcodeLowByte <= INDEXED_MAX)
                addr_next = ptr_reg[2] + {6'h00, opcodeLowByte};
            else if (opcodeLowByte < ACCESS_SPLIT)
                addr_next = {ACCESS_LOW_PAGE, opcodeLowByte};
            else
                addr_next = {ACCESS_HIGH_PAGE, opcodeLowByte};
        end
        else if (addrMode == AM_INDIRECT)
        begin
            addr_next = selPtr;
            case (indirectMode)
                IND_AFTER_ACCESS_INCREMENT_OPERAND: adjustPtr = 1'b1;
                IND_AFTER_ACCESS_DECREMENT_OPERAND:
                begin
                    adjustPtr = 1'b1;
                    adjustUp = 1'b0;
                end
                IND_BEFORE_ACCESS_INCREMENT_OPERAND:
                begin
                    adjustPtr = 1'b1;
                    addr_next = ptrStep(selPtr, 1'b1);
                end
                IND_WORKING_OFFSET_OPERAND:
                    addr_next = selPtr + {{6{working_reg[7]}},
                                          working_reg};
                default: adjustPtr = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            addrValid <= 1'b0;
            dataAddr <= 14'h0000;
        end
        else
        begin
            addrValid <= addrReq;
            if (addrReq)
                dataAddr <= addr_next;
        end
    end

    // ----------------------------------------
    // Pointer pairs
    // ----------------------------------------
    // A direct write to one pointer byte beats its own auto-step for that byte; the other byte still steps
    always_ff @(posedge clock or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            for (int i = 0; i < PTR_COUNT; i++)
                ptr_reg[i] <= 14'h0000;
        end
        else
        begin
            for (int i = 0; i < PTR_COUNT; i++)
            begin
                if (addrReq && addrMode == AM_INDIRECT && adjustPtr
                    && pointerSel == 2'(i))
                    ptr_reg[i] <= ptrStep(ptr_reg[i], adjustUp);
                if (regWrite && regAddr == REG_PTR_BASE + 4'(2 * i))
                    ptr_reg[i][7:0] <= regWrData;
                if (regWrite && regAddr == REG_PTR_BASE + 4'(2 * i + 1))
                    ptr_reg[i][13:8] <= regWrData[5:0];
            end
        end
    end

    // ----------------------------------------
    // Absolute target
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            branchValid <= 1'b0;
            branchTarget <= 20'h00000;
        end
        else
        begin
            branchValid <= branchReq;
            if (branchReq)
                branchTarget <= {opcodeSecond[11:0],
                                 opcodeFirst[7:0]};
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    logic [7:0] rd_next;

    always_comb
    begin
        rd_next = 8'h00;
        if (regAddr == REG_FLAGS)
            rd_next = {1'b0, flags_reg[6:0]};
        else if (regAddr == REG_WORKING)
            rd_next = working_reg;
        else if (regAddr == REG_BANK)
            rd_next = bank_reg;
        else if (regAddr == REG_SAVED_FLAGS)
            rd_next = savedFlags_reg;
        else if (regAddr == REG_SAVED_WORKING)
            rd_next = savedWorking_reg;
        else if (regAddr == REG_SAVED_BANK)
            rd_next = savedBank_reg;
        else
        begin
            for (int i = 0; i < PTR_COUNT; i++)
            begin
                if (regAddr == REG_PTR_BASE + 4'(2 * i))
                    rd_next = ptr_reg[i][7:0];
                else if (regAddr == REG_PTR_BASE + 4'(2 * i + 1))
                    rd_next = {2'b00, ptr_reg[i][13:8]};
            end
        end
    end

    always_ff @(posedge clock or negedge rstSyncN)
    begin
        if (!rstSyncN)
            regRdData <= 8'h00;
        else if (regRead)
            regRdData <= rd_next;
        else
            regRdData <= 8'h00;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [13:0] ptr0Now;
    assign ptr0Now = ptr_reg[0];

    a_flag_top_zero: assert property (
        regRead && regAddr == REG_FLAGS |=> !regRdData[7])
        else $error("flag register top bit read as one");

    a_call_save_all: assert property (
        callEvent |=> savedWorking_reg == $past(working_reg)
            && savedBank_reg == $past(bank_reg)
            && savedFlags_reg == $past(flags_reg))
        else $error("call did not save working, bank and flags");

    a_flag_dest_drop: assert property (
        execStart && flagOp && targetIsFlags |=> resultValid
            && !resultWriteFile && !resultToWorking)
        else $error("flag register target result was written");

    a_sub_borrow: assert property (
        execStart && aluOp == OP_SUB |=> flags_reg[FLAG_C]
            == ($past(fileOperand) >= $past(opB)))
        else $error("subtract carry is not inverted borrow");

    a_zero_neg: assert property (
        execStart && aluOp == OP_ADD |=> flags_reg[FLAG_Z]
            == (resultData == 8'h00)
            && flags_reg[FLAG_N] == resultData[7])
        else $error("zero or negative flag wrong after add");

    a_neutral_ops: assert property (
        execStart && !flagOp && !targetIsFlags
            && !(regWrite && regAddr == REG_FLAGS)
            |=> $stable(flags_reg[4:0]))
        else $error("flag-neutral operation changed flags");

    a_sleep_flags: assert property (
        sleepInstr && !watchdogClearInstr && !watchdogTimeout
            |=> flags_reg[FLAG_TO] && !flags_reg[FLAG_PD])
        else $error("sleep did not set expiry and clear sleep flag");

    a_timeout_flag: assert property (
        watchdogTimeout |=> !flags_reg[FLAG_TO] ##1
            (flags_reg[FLAG_TO] == $past((watchdogClearInstr
             || sleepInstr) && !watchdogTimeout)))
        else $error("expiry flag wrong after watchdog time-out");

    a_bank_address: assert property (
        addrReq && addrMode == AM_DIRECT && accessSelect |=> addrValid
            && dataAddr == {$past(bank_reg[5:0]),
                            $past(opcodeLowByte)})
        else $error("banked address not formed from bank and byte");

    a_after_access_increment_operand_step: assert property (
        addrReq && addrMode == AM_INDIRECT && indirectMode == IND_AFTER_ACCESS_INCREMENT_OPERAND
            && pointerSel == 2'd0 && !regWrite
            |=> dataAddr == $past(ptr0Now)
            && ptr0Now == $past(ptr0Now) + 14'h0001)
        else $error("post-increment did not use then step pointer");

endmodule
`default_nettype wire

/* File: data_mem_model.sv */
// Behavioural data memory behind the slice's result write port
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
(
    input wire logic clock,
    input wire logic writeEn,
    input wire logic [13:0] addr,
    input wire logic [7:0] data,
    output logic [13:0] lastAddr,
    output logic [7:0] lastData
);
    // Only the last write kept; enough to see where results land
    always_ff @(posedge clock)
        if (writeEn)
        begin
            lastAddr <= addr;
            lastData <= data;
        end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the flag and address slice
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cpu_flags_pkg::*;
;
logic clock, rstn, regWrite, regRead, extendedIsaEnable, execStart;
logic useLiteral, destToFile, addrReq, accessSelect, branchReq;
logic callEvent, watchdogClearInstr, sleepInstr, watchdogTimeout;
logic resultValid, resultToWorking, resultWriteFile, addrValid, branchValid;
logic [3:0] regAddr, evt;
logic [7:0] regWrData, regRdData, fileOperand, literal, opcodeLowByte;
logic [7:0] resultData, memData, rd, a, w, e;
logic [2:0] bitIndex;
logic [1:0] pointerSel;
logic [13:0] targetAddr, longAddr, dataAddr, memAddr, lg;
logic [15:0] opcodeFirst, opcodeSecond;
logic [19:0] branchTarget;
logic [31:0] seed, u;
alu_op_t aluOp;
addr_mode_t addrMode;
ind_mode_t indirectMode;
int miscompares, checks, i;
logic [15:0] corner [4] = '{16'h7F01, 16'h0F01, 16'h8080, 16'h0000};
logic [5:0] wdt [3] = '{6'h0A, 6'h04, 6'h13};
logic [13:0] ind [5] = '{14'h00FF, 14'h00FF, 14'h0100, 14'h0100, 14'h015A};
assign {callEvent, watchdogClearInstr, sleepInstr, watchdogTimeout} = evt;
cpu_flags_addr i_dut (.*);
data_mem_model i_mem (.clock(clock), .writeEn(resultWriteFile),
    .addr(targetAddr), .data(resultData), .lastAddr(memAddr),
    .lastData(memData));
initial
begin
    clock = 0;
    forever #20 clock = ~clock;
end
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
// Expected N, OV, Z, DC, C of an add or a complement-add subtract
function automatic logic [4:0] arith(input logic [7:0] x, y, input logic s);
    logic [7:0] b;
    logic [8:0] r;
    logic [4:0] h;
    b = s ? ~y : y;
    r = x + b + s;
    h = x[3:0] + b[3:0] + s;
    return {r[7], x[7] == b[7] && r[7] != x[7], r[7:0] == 0, h[4], r[8]};
endfunction
task automatic check(input string name, input logic [19:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
        miscompares++;
        $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
endtask
task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task automatic regWr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1;
    regAddr <= ad;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 0;
endtask
task automatic regRd(input logic [3:0] ad);
    @(posedge clock);
    regRead <= 1;
    regAddr <= ad;
    @(posedge clock);
    regRead <= 0;
    #1 rd = regRdData;
endtask
task automatic ev(input logic [3:0] v);
    @(posedge clock);
    evt <= v;
    @(posedge clock);
    evt <= 0;
endtask
task automatic exec(input alu_op_t op, input logic [7:0] x, y,
                    input logic d, input logic [13:0] t);
    u = rnd();
    @(posedge clock);
    execStart <= 1;
    aluOp <= op;
    fileOperand <= x;
    useLiteral <= u[0];
    literal <= y;
    destToFile <= d;
    targetAddr <= t;
    @(posedge clock);
    execStart <= 0;
    #1 check("result valid", resultValid, 1);
endtask
task automatic areq(input addr_mode_t m, input logic [7:0] b,
                    input logic s, input ind_mode_t im);
    u = rnd();
    lg = u[13:0];
    @(posedge clock);
    addrReq <= 1;
    addrMode <= m;
    opcodeLowByte <= b;
    accessSelect <= s;
    indirectMode <= im;
    longAddr <= lg;
    @(posedge clock);
    addrReq <= 0;
    #1 check("addr valid", addrValid, 1);
endtask
initial
begin
    repeat (3000) @(posedge clock);
    miscompares++;
    finish_test();
end
initial
begin
    {rstn, regWrite, regRead, execStart, useLiteral, destToFile} = 0;
    {addrReq, accessSelect, branchReq, extendedIsaEnable, evt} = 0;
    {regAddr, regWrData, fileOperand, literal, bitIndex, targetAddr} = 0;
    {longAddr, opcodeLowByte, pointerSel, opcodeFirst, opcodeSecond} = 0;
    aluOp = OP_ADD;
    addrMode = AM_DIRECT;
    indirectMode = IND_PLAIN;
    seed = 89691;
    repeat (2) @(posedge clock);
    rstn <= 1;
    repeat (3) @(posedge clock);
    regRd(REG_FLAGS);
    check("flags reset", rd, FLAGS_RESET);
    regRd(4'hF);
    check("unmapped", rd, 0);
    for (i = 0; i < 40; i++)
    begin
        {a, w} = i < 4 ? corner[i] : 16'(rnd());
        regWr(REG_WORKING, w);
        exec(i[0] ? OP_SUB : OP_ADD, a, w, 0, 14'h0100);
        check("to working", resultToWorking, 1);
        rd = i[0] ? a - w : a + w;
        check("sum", resultData, rd);
        regRd(REG_FLAGS);
        check("flags", rd,
              {3'b011, arith(a, w, i[0])});
    end
    $display("arithmetic test done");
    regWr(REG_FLAGS, 8'hFB);
    exec(OP_MOVE, 8'h00, 8'h00, 1, 14'h0123);
    regRd(REG_FLAGS);
    check("move flags", rd, 8'h7B);
    check("file write", memAddr, 14'h0123);
    exec(OP_CLR, 8'h55, 8'h00, 1, FLAGS_DATA_ADDR);
    check("no file write", resultWriteFile, 0);
    regRd(REG_FLAGS);
    check("clear flags", rd, 8'h7F);
    exec(OP_RLC, 8'h81, 8'h00, 1, 14'h0100);
    regRd(REG_FLAGS);
    check("rotate flags", rd, 8'h6B);
    check("rotate data", memData, 8'h03);
    regWr(REG_WORKING, 8'h5A);
    regWr(REG_BANK, 8'hD5);
    ev(4'b1000);
    regRd(REG_SAVED_WORKING);
    check("saved working", rd, 8'h5A);
    regRd(REG_SAVED_BANK);
    check("saved bank", rd, 8'h15);
    regRd(REG_SAVED_FLAGS);
    check("saved flags", rd, 8'h6B);
    for (i = 0; i < 3; i++)
    begin
        ev(wdt[i][5:2]);
        regRd(REG_FLAGS);
        check("power flags", rd[6:5], wdt[i][1:0]);
    end
    $display("flag register test done");
    areq(AM_DIRECT, 8'h34, 1, IND_PLAIN);
    check("banked", dataAddr, 14'h1534);
    areq(AM_DIRECT, 8'h80, 0, IND_PLAIN);
    check("access high", dataAddr, 14'h3F80);
    areq(AM_DIRECT, 8'h20, 0, IND_PLAIN);
    check("access low", dataAddr, 14'h0020);
    areq(AM_LONG, 8'h20, 1, IND_PLAIN);
    check("long", dataAddr, lg);
    regWr(4'h6, 8'hFF);
    regWr(4'h7, 8'hC0);
    for (i = 0; i < 5; i++)
    begin
        areq(AM_INDIRECT, 8'h00, 0, ind_mode_t'(i));
        check("indirect", dataAddr, ind[i]);
    end
    regRd(4'h7);
    check("pointer high", rd, 8'h01);
    regRd(REG_FLAGS);
    check("step flags", rd, 8'h6B);
    regWr(4'hA, 8'h40);
    regWr(4'hB, 8'h00);
    extendedIsaEnable <= 1;
    areq(AM_DIRECT, 8'h10, 0, IND_PLAIN);
    check("indexed", dataAddr, 14'h0050);
    pointerSel <= 2'd2;
    areq(AM_INDIRECT, 8'h00, 0, IND_AFTER_ACCESS_DECREMENT_OPERAND);
    check("pointer two", dataAddr, 14'h0040);
    regRd(4'hA);
    check("pointer two step", rd, 8'h3F);
    $display("addressing test done");
    for (i = 0; i < 9; i++)
    begin
        {a, w} = i == 0 ? 16'h0F70 : 16'(rnd());
        regWr(REG_WORKING, w);
        regWr(REG_FLAGS, 8'h00);
        exec(alu_op_t'(i % 3 + 2), a, w, 0, 14'h0100);
        e = i % 3 == 0 ? a & w : i % 3 == 1 ? a | w : a ^ w;
        check("logic", resultData, e);
        regRd(REG_FLAGS);
        check("logic flags", rd,
              {3'b011, e[7], 1'b0, e == 8'h00, 2'b00});
    end
    bitIndex <= 3'd6;
    exec(OP_BSET, 8'h10, 8'h00, 1, 14'h0200);
    check("bit set", resultData, 8'h50);
    exec(OP_SWAP, 8'hA5, 8'h00, 1, FLAGS_DATA_ADDR);
    check("swap no write", resultWriteFile, 0);
    regRd(REG_FLAGS);
    check("swap flags", rd, 8'h7A);
    $display("logic test done");
    u = rnd();
    @(posedge clock);
    branchReq <= 1;
    opcodeFirst <= u[15:0];
    opcodeSecond <= u[31:16];
    @(posedge clock);
    branchReq <= 0;
    #1 check("target", branchTarget, {u[27:16], u[7:0]});
    check("branch valid", branchValid, 1);
    $display("branch test done");
    finish_test();
end
endmodule
`default_nettype wire
